// file: src/xsd_ext_decode.sv
// Decode and execute of the stack-oriented instruction extension.
// Assumes one clk per instruction cycle, data reads answered one clk later,
// and the core holds off new words while busy is high.
module xsd_ext_decode
  import xsd_pkg::*;
#(
  parameter int unsigned DATA_ADDR_W = 12
)(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              extension_enable_bit,
  input  wire logic              instr_valid,
  input  wire logic [15:0]       instr,
  input  wire logic              std_op_valid,
  input  wire logic [7:0]        working_register,
  input  wire logic [7:0]        counter_high_latch,
  input  wire logic [7:0]        counter_upper_latch,
  input  wire logic [PC_W-1:0]   next_pc,
  input  wire logic [PC_W-1:0]   return_stack_top,
  input  wire logic [7:0]        mem_rd_data,
  input  wire logic [3:0]        bank_select_register,
  input  wire logic              ptr_load_en,
  input  wire logic [1:0]        ptr_load_sel,
  input  wire logic [ADDR_W-1:0] ptr_load_value,
  output xsd_mem_req_t           mem_req,
  output xsd_flow_t              flow,
  output logic [ADDR_W-1:0]      std_addr,
  output logic                   std_addr_valid,
  output logic                   ext_active,
  output logic                   ext_claimed,
  output logic                   busy,
  output logic [ADDR_W-1:0]      indirect_pointer0,
  output logic [ADDR_W-1:0]      indirect_pointer1,
  output logic [ADDR_W-1:0]      software_stack_pointer
);

  if (DATA_ADDR_W != ADDR_W) begin : g_bad_width
    $error("xsd_ext_decode: only a 12-bit data space is supported");
  end

  // ==========================================================
  // Configuration strap
  logic strap_done_reg, strap_done_next;
  logic ext_en_reg, ext_en_next;

  // Caught on the first edge after reset, never under the reset itself
  always_comb begin
    strap_done_next = 1'b1;
    ext_en_next     = strap_done_reg ? ext_en_reg : extension_enable_bit;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_done_reg <= 1'b0;
      ext_en_reg     <= 1'b0;
    end else begin
      strap_done_reg <= strap_done_next;
      ext_en_reg     <= ext_en_next;
    end
  end

  // ==========================================================
  // Execute state
  xsd_state_t        state_reg, state_next;
  logic [ADDR_W-1:0] ptr_reg  [3];
  logic [ADDR_W-1:0] ptr_next [3];
  xsd_mem_req_t      req_reg, req_next;
  xsd_flow_t         flow_reg, flow_next;
  logic              claim_reg, claim_next;
  logic              kind_reg, kind_next;
  logic              src_ind_reg, src_ind_next;
  logic              rdp_reg, rdp_next;
  logic [7:0]        data_reg, data_next;
  logic              busy_reg;
  logic [ADDR_W-1:0] sp;
  logic              idle_go;

  assign sp      = ptr_reg[SP_IDX];
  assign idle_go = instr_valid && state_reg == S_IDLE && ext_en_reg;

  always_comb begin
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] dst;
    logic [ADDR_W-1:0] k;
    logic [1:0]        sel;
    src          = 12'(sp + {5'h00, instr[6:0]});
    dst          = '0;
    k            = {6'h00, instr[5:0]};
    sel          = instr[7:6];
    state_next   = state_reg;
    req_next     = '0;
    flow_next    = '0;
    claim_next   = 1'b0;
    kind_next    = kind_reg;
    src_ind_next = src_ind_reg;
    rdp_next     = 1'b0;
    data_next    = rdp_reg ? mem_rd_data : data_reg;
    for (int i = 0; i < 3; i++) begin
      ptr_next[i] = ptr_reg[i];
    end
    // Core loads lose to an extended op that updates the same pointer
    if (ptr_load_en && ptr_load_sel != SEL_STACK) begin
      ptr_next[ptr_load_sel] = ptr_load_value;
    end
    case (state_reg)
      S_IDLE: begin
        if (idle_go && instr[15:8] == OP_MOVE) begin
          req_next.rd_en   = 1'b1;
          req_next.rd_addr = src;
          src_ind_next     = xsd_is_indirect(src);
          kind_next        = instr[MOVE_KIND];
          rdp_next         = 1'b1;
          claim_next       = 1'b1;
          state_next       = S_WORD2;
        end else if (idle_go && instr[15:8] == OP_PUSH) begin
          req_next.wr_en   = 1'b1;
          req_next.wr_addr = sp;
          req_next.wr_data = instr[7:0];
          ptr_next[SP_IDX] = 12'(sp - 12'h001);
          claim_next       = 1'b1;
        end else if (idle_go && (instr[15:8] == OP_ADD || instr[15:8] == OP_SUB)) begin
          claim_next = 1'b1;
          if (sel == SEL_STACK) begin
            ptr_next[SP_IDX] = (instr[8] == OP_ADD[0]) ? 12'(sp + k) : 12'(sp - k);
            flow_next.pc_load  = 1'b1;
            flow_next.pc_value = return_stack_top;
            state_next         = S_NOP;
          end else begin
            ptr_next[sel] = (instr[8] == OP_ADD[0]) ? 12'(ptr_reg[sel] + k)
                                                    : 12'(ptr_reg[sel] - k);
          end
        end else if (idle_go && instr == OP_CALL_VIA_WORKING) begin
          claim_next           = 1'b1;
          flow_next.push       = 1'b1;
          flow_next.push_value = next_pc;
          flow_next.pc_load    = 1'b1;
          flow_next.pc_value   = {counter_upper_latch[4:0], counter_high_latch,
                                  working_register};
          state_next           = S_NOP;
        end
      end
      S_WORD2: begin
        if (instr_valid) begin
          dst = kind_reg ? 12'(sp + {5'h00, instr[6:0]}) : instr[11:0];
          req_next.wr_addr = dst;
          req_next.wr_en   = !(kind_reg && xsd_is_indirect(dst)) &&
                             !xsd_is_flow_reg(dst);
          req_next.wr_data = src_ind_reg ? 8'h00 : data_next;
          state_next       = S_IDLE;
        end
      end
      S_NOP: begin
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg   <= S_IDLE;
      req_reg     <= '0;
      flow_reg    <= '0;
      claim_reg   <= 1'b0;
      kind_reg    <= 1'b0;
      src_ind_reg <= 1'b0;
      rdp_reg     <= 1'b0;
      data_reg    <= 8'h00;
      busy_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      req_reg     <= req_next;
      flow_reg    <= flow_next;
      claim_reg   <= claim_next;
      kind_reg    <= kind_next;
      src_ind_reg <= src_ind_next;
      rdp_reg     <= rdp_next;
      data_reg    <= data_next;
      busy_reg    <= state_next != S_IDLE;
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_ptr
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        ptr_reg[g] <= PTR_RST;
      end else begin
        ptr_reg[g] <= ptr_next[g];
      end
    end
  end

  // ==========================================================
  // Standard operand address
  logic [ADDR_W-1:0] std_addr_next;
  logic [ADDR_W-1:0] std_addr_reg;
  logic              std_valid_reg;

  xsd_operand_addr u_operand (
    .stack_ptr            (sp),
    .ext_en               (ext_en_reg),
    .file_operand         (instr[7:0]),
    .bank_mode            (instr[ACCESS_BIT]),
    .bank_select_register (bank_select_register),
    .data_addr            (std_addr_next)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      std_addr_reg  <= 12'h000;
      std_valid_reg <= 1'b0;
    end else begin
      std_addr_reg  <= std_addr_next;
      std_valid_reg <= std_op_valid;
    end
  end

  assign mem_req                = req_reg;
  assign flow                   = flow_reg;
  assign std_addr               = std_addr_reg;
  assign std_addr_valid         = std_valid_reg;
  assign ext_active             = ext_en_reg;
  assign ext_claimed            = claim_reg;
  assign busy                   = busy_reg;
  assign indirect_pointer0      = ptr_reg[0];
  assign indirect_pointer1      = ptr_reg[1];
  assign software_stack_pointer = ptr_reg[SP_IDX];

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [ADDR_W-1:0] chk_src;
  logic [ADDR_W-1:0] chk_idx_dst;
  logic [ADDR_W-1:0] chk_std;
  assign chk_src     = 12'(sp + {5'h00, instr[6:0]});
  assign chk_idx_dst = chk_src;
  assign chk_std     = 12'(sp + {4'h0, instr[7:0]});

  sequence s_move_first;
    idle_go && instr[15:8] == OP_MOVE;
  endsequence
  sequence s_word2;
    state_reg == S_WORD2 && instr_valid;
  endsequence

  property p_move_src;
    s_move_first |=> mem_req.rd_en && mem_req.rd_addr == $past(chk_src);
  endproperty
  a_move_src: assert property (p_move_src) else $error("indexed source address wrong");

  property p_move_abs;
    s_word2 and (!kind_reg && !xsd_is_flow_reg(instr[11:0]))
      |=> mem_req.wr_en && mem_req.wr_addr == $past(instr[11:0]);
  endproperty
  a_move_abs: assert property (p_move_abs) else $error("absolute destination wrong");

  property p_move_len;
    s_move_first ##1 s_word2 |=> state_reg == S_IDLE && !busy;
  endproperty
  a_move_len: assert property (p_move_len) else $error("move not two cycles");

  property p_no_flow_dest;
    s_word2 and (xsd_is_flow_reg(kind_reg ? chk_idx_dst : instr[11:0])) |=> !mem_req.wr_en;
  endproperty
  a_no_flow_dest: assert property (p_no_flow_dest) else $error("flow register written");

  property p_src_ind;
    s_word2 and (src_ind_reg) |=> mem_req.wr_data == 8'h00;
  endproperty
  a_src_ind: assert property (p_src_ind) else $error("indirect source not zero");

  property p_dst_ind;
    s_word2 and (kind_reg && xsd_is_indirect(chk_idx_dst)) |=> !mem_req.wr_en;
  endproperty
  a_dst_ind: assert property (p_dst_ind) else $error("indirect destination written");

  property p_push;
    idle_go && instr[15:8] == OP_PUSH
      |=> mem_req.wr_en && mem_req.wr_addr == $past(sp)
          && software_stack_pointer == 12'($past(sp) - 12'h001);
  endproperty
  a_push: assert property (p_push) else $error("push literal wrong");

  property p_sub_ret;
    idle_go && instr[15:8] == OP_SUB && instr[7:6] == SEL_STACK
      |=> flow.pc_load && flow.pc_value == $past(return_stack_top)
          ##1 !flow.pc_load && !mem_req.wr_en && !ext_claimed;
  endproperty
  a_sub_ret: assert property (p_sub_ret) else $error("subtract and return wrong");

  property p_call_via_working;
    idle_go && instr == OP_CALL_VIA_WORKING
      |=> flow.push && flow.push_value == $past(next_pc) && flow.pc_load ##1 !flow.pc_load;
  endproperty
  a_call_via_working: assert property (p_call_via_working) else $error("call via working wrong");

  property p_std_index;
    std_op_valid && ext_en_reg && !instr[ACCESS_BIT] && instr[7:0] <= ACCESS_SPLIT
      |=> std_addr_valid && std_addr == $past(chk_std);
  endproperty
  a_std_index: assert property (p_std_index) else $error("indexed operand wrong");

  property p_disabled;
    !ext_en_reg |=> !ext_claimed;
  endproperty
  a_disabled: assert property (p_disabled) else $error("extended op while disabled");

endmodule

// file: src/xsd_operand_addr.sv
// Resolves the file operand of standard byte and bit instructions.
// Purely combinational; the caller registers the result.
module xsd_operand_addr
  import xsd_pkg::*;
(
  input  wire logic [ADDR_W-1:0] stack_ptr,
  input  wire logic              ext_en,
  input  wire logic [7:0]        file_operand,
  input  wire logic              bank_mode,
  input  wire logic [3:0]        bank_select_register,
  output logic      [ADDR_W-1:0] data_addr
);

  always_comb begin
    if (bank_mode) begin
      data_addr = {bank_select_register, file_operand};
    end else if (file_operand <= ACCESS_SPLIT) begin
      // Same enable as the opcodes, so both modes switch together
      if (ext_en) begin
        data_addr = 12'(stack_ptr + {4'h0, file_operand});
      end else begin
        data_addr = {4'h0, file_operand};
      end
    end else begin
      data_addr = {ACCESS_HI, file_operand};
    end
  end

endmodule

// file: src/xsd_pkg.sv
// Constants, types and shared decode helpers for the extended stack
// instruction decoder. Assumes a 12-bit data space and a 21-bit program counter.
//
// Notes on behaviour
// - Indexed-to-file source address is stack pointer plus 7-bit offset from word one.
// - Indexed-to-file destination is the 12-bit absolute field of word two.
// - Indexed-to-file uses words EBh/0 plus offset, then F plus address; two cycles.
// - Program counter low and return stack top bytes are never move destinations.
// - Source landing on an indirect register moves 00h.
// - Indexed-to-indexed destination on an indirect register writes nothing.
// - Indexed-to-indexed adds separate 7-bit offsets to stack pointer; two words, two cycles.
// - Move addresses cover the full 4096-byte data space.
// - Push literal writes immediate at stack pointer, then decrements it; one cycle.
// - Subtract 6-bit immediate from pointer selected 0 to 2; flags untouched; one cycle.
// - Select 11 subtracts from stack pointer, returns from stack top, then idles.
// - Extension on, access bit clear, operand up to 5Fh addresses stack pointer plus operand.
// - Extension off, operand is literal: access bank or bank select register bank.
// - One enable turns on both extended opcodes and indexed operand addressing.
// - Stack pointer 00h makes indexed operands reach original access locations.
// - Extension is off by default; enabled only by the configuration bit.
// - Call via working pushes next address, loads counter from working and latches.
// - Add counterpart adds immediate; select 11 adds to stack pointer and returns.
package xsd_pkg;

  // ==========================================================
  // Widths
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned PC_W   = 21;

  // ==========================================================
  // Opcodes and field positions
  localparam logic [7:0]  OP_MOVE      = 8'hEB;
  localparam logic [7:0]  OP_ADD       = 8'hE8;
  localparam logic [7:0]  OP_SUB       = 8'hE9;
  localparam logic [7:0]  OP_PUSH      = 8'hFA;
  localparam logic [15:0] OP_CALL_VIA_WORKING     = 16'h0014;
  localparam logic [3:0]  WORD2_PFX    = 4'hF;
  localparam int unsigned MOVE_KIND    = 7;
  localparam int unsigned ACCESS_BIT   = 8;
  localparam logic [1:0]  SEL_STACK    = 2'b11;
  localparam int unsigned SP_IDX       = 2;

  // ==========================================================
  // Data map
  localparam logic [7:0]  ACCESS_SPLIT = 8'h5F;
  localparam logic [3:0]  ACCESS_HI    = 4'hF;
  localparam logic [11:0] PTR_RST      = 12'h000;
  localparam logic [11:0] IND_BASE0    = 12'hFDB;
  localparam logic [11:0] IND_BASE1    = 12'hFE3;
  localparam logic [11:0] IND_BASE2    = 12'hFEB;
  localparam logic [11:0] IND_SPAN     = 12'h005;
  localparam logic [11:0] PC_LOW_ADDR  = 12'hFF9;
  localparam logic [11:0] TOP_LOW_ADDR = 12'hFFD;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_WORD2 = 2'b01,
    S_NOP   = 2'b10
  } xsd_state_t;

  typedef struct packed {
    logic              rd_en;
    logic [ADDR_W-1:0] rd_addr;
    logic              wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0]        wr_data;
  } xsd_mem_req_t;

  typedef struct packed {
    logic            pc_load;
    logic [PC_W-1:0] pc_value;
    logic            push;
    logic [PC_W-1:0] push_value;
  } xsd_flow_t;

  // Any of the indirect access windows
  function automatic logic xsd_is_indirect(input logic [ADDR_W-1:0] a);
    xsd_is_indirect = (a >= IND_BASE0 && a < 12'(IND_BASE0 + IND_SPAN)) ||
                      (a >= IND_BASE1 && a < 12'(IND_BASE1 + IND_SPAN)) ||
                      (a >= IND_BASE2 && a < 12'(IND_BASE2 + IND_SPAN));
  endfunction

  function automatic logic xsd_is_flow_reg(input logic [ADDR_W-1:0] a);
    xsd_is_flow_reg = (a == PC_LOW_ADDR) || (a >= TOP_LOW_ADDR);
  endfunction

endpackage

// file: testbench/tb_top.sv
// Self-checking bench for the extended stack instruction decoder.
// Assumes xsd_core_model as memory and return stack, 50 MHz clock.
module tb_top
  import xsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk;
  logic              rst;
  logic              extension_enable_bit;
  logic              instr_valid;
  logic [15:0]       instr;
  logic              std_op_valid;
  logic [7:0]        working_register;
  logic [7:0]        counter_high_latch;
  logic [7:0]        counter_upper_latch;
  logic [PC_W-1:0]   next_pc;
  logic [PC_W-1:0]   return_stack_top;
  logic [7:0]        mem_rd_data;
  logic [3:0]        bank_select_register;
  logic              ptr_load_en;
  logic [1:0]        ptr_load_sel;
  logic [ADDR_W-1:0] ptr_load_value;
  xsd_mem_req_t      mem_req;
  xsd_flow_t         flow;
  logic [ADDR_W-1:0] std_addr;
  logic              std_addr_valid;
  logic              ext_active;
  logic              ext_claimed;
  logic              busy;
  logic [ADDR_W-1:0] indirect_pointer0;
  logic [ADDR_W-1:0] indirect_pointer1;
  logic [ADDR_W-1:0] software_stack_pointer;
  int                n_fail;
  int                check_count;
  logic [ADDR_W-1:0] p;

  xsd_ext_decode u_xsd_ext_decode (.*);
  xsd_core_model u_xsd_core_model (.clk, .mem_req, .flow, .mem_rd_data, .return_stack_top);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ======
  // Helpers
  task automatic chk(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic op1(input logic [15:0] w, input logic s);
    @(posedge clk);
    instr_valid  <= 1'b1;
    std_op_valid <= s;
    instr        <= w;
    @(posedge clk);
    instr_valid  <= 1'b0;
    std_op_valid <= 1'b0;
    #1;
  endtask

  // Second word follows the first with no gap
  task automatic op2(input logic [15:0] w1, input logic [15:0] w2);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr       <= w1;
    @(posedge clk);
    instr       <= w2;
    @(posedge clk);
    instr_valid <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic load_ptr(input logic [1:0] s, input logic [11:0] v);
    @(posedge clk);
    ptr_load_en    <= 1'b1;
    ptr_load_sel   <= s;
    ptr_load_value <= v;
    @(posedge clk);
    ptr_load_en    <= 1'b0;
    #1;
  endtask

  task automatic do_reset(input logic en);
    @(posedge clk);
    rst                  <= 1'b1;
    extension_enable_bit <= en;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // ======
  // Scenarios
  task automatic t_disabled;
    do_reset(1'b0);
    chk_bit(ext_active, 1'b0);
    load_ptr(2'd2, 12'hA00);
    op1(16'hFA55, 1'b0);
    chk_bit(ext_claimed, 1'b0);
    chk_bit(mem_req.wr_en, 1'b0);
    op1(16'hE9A3, 1'b0);
    chk(PC_W'(software_stack_pointer), 21'h00_0A00);
    op1(16'h6A2C, 1'b1);
    chk_bit(std_addr_valid, 1'b1);
    chk(PC_W'(std_addr), 21'h00_002C);
    @(posedge clk);
    bank_select_register <= 4'h3;
    op1(16'h6B2C, 1'b1);
    chk(PC_W'(std_addr), 21'h00_032C);
    $display("test disabled done");
  endtask

  task automatic t_indexed;
    do_reset(1'b1);
    chk_bit(ext_active, 1'b1);
    load_ptr(2'd2, 12'hA00);
    op1(16'h6A2C, 1'b1);
    chk(PC_W'(std_addr), 21'h00_0A2C);
    op1(16'h6A5F, 1'b1);
    chk(PC_W'(std_addr), 21'h00_0A5F);
    op1(16'h6A60, 1'b1);
    chk(PC_W'(std_addr), 21'h00_0F60);
    op1(16'h6B2C, 1'b1);
    chk(PC_W'(std_addr), 21'h00_032C);
    load_ptr(2'd2, 12'h000);
    op1(16'h6A2C, 1'b1);
    chk(PC_W'(std_addr), 21'h00_002C);
    $display("test indexed operand done");
  endtask

  task automatic t_push;
    load_ptr(2'd2, 12'h1EC);
    op1(16'hFA08, 1'b0);
    chk_bit(ext_claimed, 1'b1);
    chk_bit(mem_req.wr_en, 1'b1);
    chk(PC_W'(mem_req.wr_addr), 21'h00_01EC);
    chk(PC_W'(mem_req.wr_data), 21'h00_0008);
    chk(PC_W'(software_stack_pointer), 21'h00_01EB);
    load_ptr(2'd2, 12'h000);
    op1(16'hFA77, 1'b0);
    chk(PC_W'(mem_req.wr_addr), 21'h00_0000);
    chk(PC_W'(software_stack_pointer), 21'h00_0FFF);
    $display("test push done");
  endtask

  task automatic t_ptr_math;
    for (int s = 0; s < 3; s++) begin
      load_ptr(2'(s), 12'h3FF);
      op1({8'hE8, 2'(s), 6'h23}, 1'b0);
      p = (s == 0) ? indirect_pointer0 : (s == 1) ? indirect_pointer1 : software_stack_pointer;
      chk(PC_W'(p), 21'h00_0422);
      op1({8'hE9, 2'(s), 6'h3F}, 1'b0);
      p = (s == 0) ? indirect_pointer0 : (s == 1) ? indirect_pointer1 : software_stack_pointer;
      chk(PC_W'(p), 21'h00_03E3);
      chk_bit(busy, 1'b0);
    end
    load_ptr(2'd1, 12'h005);
    op1(16'hE97F, 1'b0);
    chk(PC_W'(indirect_pointer1), 21'h00_0FC6);
    $display("test pointer arithmetic done");
  endtask

  task automatic t_return;
    u_xsd_core_model.top_reg = 21'h01_2340;
    load_ptr(2'd2, 12'h3FF);
    op1(16'hE9E3, 1'b0);
    chk(PC_W'(software_stack_pointer), 21'h00_03DC);
    chk_bit(flow.pc_load, 1'b1);
    chk(flow.pc_value, 21'h01_2340);
    chk_bit(busy, 1'b1);
    @(posedge clk);
    #1;
    chk_bit(flow.pc_load, 1'b0);
    op1(16'hE8E3, 1'b0);
    chk(PC_W'(software_stack_pointer), 21'h00_03FF);
    chk_bit(flow.pc_load, 1'b1);
    $display("test return done");
  endtask

  task automatic t_call;
    @(posedge clk);
    working_register    <= 8'h06;
    counter_high_latch  <= 8'h10;
    counter_upper_latch <= 8'hE3;
    next_pc             <= 21'h00_0102;
    op1(16'h0014, 1'b0);
    chk_bit(flow.push, 1'b1);
    chk(flow.push_value, 21'h00_0102);
    chk_bit(flow.pc_load, 1'b1);
    chk(flow.pc_value, 21'h03_1006);
    chk_bit(busy, 1'b1);
    $display("test call done");
  endtask

  task automatic t_move;
    u_xsd_core_model.mem[12'h085] = 8'h33;
    u_xsd_core_model.mem[12'hFFF] = 8'h5A;
    u_xsd_core_model.mem[12'h124] = 8'h77;
    u_xsd_core_model.mem[12'hFDB] = 8'hAA;
    u_xsd_core_model.mem[12'hFF9] = 8'hBB;
    load_ptr(2'd2, 12'h080);
    op2(16'hEB05, 16'hF123);
    chk(PC_W'(u_xsd_core_model.mem[12'h123]), 21'h00_0033);
    op2(16'hEB85, 16'hF006);
    chk(PC_W'(u_xsd_core_model.mem[12'h086]), 21'h00_0033);
    load_ptr(2'd2, 12'hF80);
    op2(16'hEB7F, 16'hFF00);
    chk(PC_W'(u_xsd_core_model.mem[12'hF00]), 21'h00_005A);
    op2(16'hEB5B, 16'hF124);
    chk(PC_W'(u_xsd_core_model.mem[12'h124]), 21'h00_0000);
    op2(16'hEB85, 16'hF05B);
    chk(PC_W'(u_xsd_core_model.mem[12'hFDB]), 21'h00_00AA);
    op2(16'hEB7F, 16'hFFF9);
    chk(PC_W'(u_xsd_core_model.mem[12'hFF9]), 21'h00_00BB);
    $display("test move done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    rst                  = 1'b1;
    extension_enable_bit = 1'b0;
    instr_valid          = 1'b0;
    instr                = 16'h0000;
    std_op_valid         = 1'b0;
    working_register     = 8'h00;
    counter_high_latch   = 8'h00;
    counter_upper_latch  = 8'h00;
    next_pc              = 21'h00_0000;
    bank_select_register = 4'h0;
    ptr_load_en          = 1'b0;
    ptr_load_sel         = 2'd0;
    ptr_load_value       = 12'h000;
    n_fail               = 0;
    check_count          = 0;
    t_disabled;
    t_indexed;
    t_push;
    t_ptr_math;
    t_return;
    t_call;
    t_move;
    report_and_stop;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #200000;
    n_fail++;
    $display("ERROR at %0t: watchdog expired", $time);
    report_and_stop;
  end
endmodule

// file: testbench/xsd_core_model.sv
// Behavioural data memory and return stack top facing the decoder.
// Assumes mem_req and flow are registered one-cycle pulses from the decoder.
module xsd_core_model
  import xsd_pkg::*;
(
  input  wire logic          clk,
  input  wire xsd_mem_req_t  mem_req,
  input  wire xsd_flow_t     flow,
  output logic [7:0]         mem_rd_data,
  output logic [PC_W-1:0]    return_stack_top
);
  timeunit 1ns;
  timeprecision 1ps;

  // ======
  // Storage, preset by the bench through hierarchy
  logic [7:0]      mem [4096];
  logic [7:0]      last_reg;
  logic [PC_W-1:0] top_reg;

  // Outside a read the bus shows the inverse of the last value, never a stale copy
  always_comb begin
    mem_rd_data = mem_req.rd_en ? mem[mem_req.rd_addr] : ~last_reg;
  end

  always @(posedge clk) begin
    if (mem_req.rd_en) begin
      last_reg <= mem[mem_req.rd_addr];
    end
    if (mem_req.wr_en) begin
      mem[mem_req.wr_addr] <= mem_req.wr_data;
    end
    if (flow.push) begin
      top_reg <= flow.push_value;
    end
  end

  assign return_stack_top = top_reg;
endmodule
